// ==== san_pkg.sv ====
// Shared constants and carrier types for the authentication negotiation block
package san_pkg;

   // Response status codes (block-local encoding)
   localparam logic [7:0] SAN_ST_OK = 8'h00;
   localparam logic [7:0] SAN_ST_MORE_FRAMES = 8'haf;
   localparam logic [7:0] SAN_ST_REFUSED = 8'h9d;
   localparam logic [7:0] SAN_ST_AUTH_DELAY = 8'had;
   localparam logic [7:0] SAN_ST_AUTH_ERROR = 8'hae;

   // Capability and authentication-type byte values
   localparam logic [7:0] SAN_CAP_AES = 8'h00;
   localparam logic [7:0] SAN_CAP_RESILIENT = 8'h02;
   localparam int SAN_CAP_MODE_BIT = 1;
   localparam logic [7:0] SAN_AUTH_TYPE_RESILIENT = 8'h01;

   // Response lengths in bytes
   localparam logic [4:0] SAN_LEN_AES = 5'h11;
   localparam logic [4:0] SAN_LEN_RESILIENT = 5'h12;
   localparam logic [4:0] SAN_LEN_STATUS = 5'h01;

   // Key slots
   localparam int SAN_NUM_KEYS = 5;
   localparam logic [2:0] SAN_MASTER_KEY = 3'h0;
   localparam logic [2:0] SAN_ORIG_KEY_BASE = 3'h5;

   // Counter widths and reset values
   localparam int SAN_CNT_W = 16;
   localparam logic [15:0] SAN_FAIL_RESET = 16'h0000;
   localparam logic [7:0] SAN_CONSEC_RESET = 8'h00;

   // Delay throttle: fraction of the frame waiting time in percent, and delay budget step in cycles
   localparam int SAN_DELAY_PCT = 65;
   localparam logic [23:0] SAN_DELAY_STEP = 24'h000100;

   // Command kinds seen by this block
   typedef enum logic [2:0] {
      SAN_CMD_FIRST,
      SAN_CMD_FOLLOWON,
      SAN_CMD_RESULT,
      SAN_CMD_KEY_REPLACE,
      SAN_CMD_CONFIGURE,
      SAN_CMD_DEAUTH
   } san_cmd_t;

   // Incoming command from the frame layer
   typedef struct packed {
      san_cmd_t kind;
      logic [2:0] key_no;
      logic cap_present;
      logic [7:0] reader_cap;
      logic auth_ok;
      logic cfg_resilient;
      logic [15:0] cfg_limit;
      logic [15:0] cfg_decrement;
   } san_req_t;

   // Answer to the frame layer
   typedef struct packed {
      logic [7:0] status;
      logic [4:0] length;
      logic has_auth_type;
      logic [7:0] auth_type;
      logic [7:0] card_cap;
      logic [7:0] reader_cap;
      logic resilient;
      logic [23:0] wait_cycles;
   } san_rsp_t;

endpackage

// ==== san_delay_timer.sv ====
// Countdown that stretches each delay-error answer to a share of the frame wait
`timescale 1ns/1ps
module san_delay_timer
   import san_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Control
   input wire logic start,
   input wire logic [23:0] fwt_cycles,
   // Status
   output logic busy,
   output logic done
);

   // Remaining cycles of the current wait
   logic [23:0] remain_reg;

   // Share of the frame waiting time, computed wide to avoid overflow
   function automatic logic [23:0] share(input logic [23:0] fwt);
      logic [31:0] prod;
      prod = 32'(fwt) * 32'(SAN_DELAY_PCT);
      return 24'(prod / 32'd100);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // countdown at sixty-five percent
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         remain_reg <= 24'h000000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            // A zero share still waits one cycle
            remain_reg <= (share(fwt_cycles) == 24'h0) ? 24'h1 : share(fwt_cycles);
            busy <= 1'b1;
         end else if (busy) begin
            if (remain_reg == 24'h1) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            remain_reg <= remain_reg - 24'h1;
         end
      end
   end

   // Busy falls exactly when done pulses
   a_done_ends_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(busy) |-> done) else $error("busy fell without done");

endmodule

// ==== san_negotiator.sv ====
// Authentication mode negotiation, failure counting and delay throttle
`timescale 1ns/1ps
module san_negotiator
   import san_pkg::*;
#(
   parameter logic [7:0] CONSEC_LIMIT = 8'h03,
   parameter logic [23:0] DELAY_MAX = 24'h001000
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Command side
   input wire logic req_valid,
   input wire san_req_t req,
   input wire logic [23:0] fwt_cycles,
   // Answer side
   output logic rsp_valid,
   output san_rsp_t rsp,
   // Status
   output logic resilient_enabled,
   output logic authenticated,
   output logic throttling,
   output logic [15:0] total_failed_auth_count,
   output logic [SAN_NUM_KEYS-1:0] key_blocked
);

   //////////////////////////////////////////////////////////////////////////
   // State
   // Configured limits
   logic [15:0] failed_auth_limit_reg;
   logic [15:0] failed_auth_decrement_reg;
   // Session state
   logic session_resilient_reg;
   logic [2:0] session_key_reg;
   logic pending_reg;
   logic pending_resilient_reg;
   logic [2:0] pending_key_reg;
   // Throttle state
   logic [7:0] consec_fail_reg;
   logic [23:0] delay_total_reg;
   logic [23:0] delay_spent_reg;
   // Delay timer handshake; busy is implied by the answer state
   logic timer_done, timer_start;

   typedef enum logic [1:0] {SAN_IDLE, SAN_WAIT_DELAY} san_state_t;
   san_state_t state_reg;

   // Decoded request events
   logic take;
   logic is_first;
   logic is_followon;
   logic is_result;
   logic key_ok;
   logic genuine_key;
   logic reader_wants_res;
   logic fail_event, ok_event;
   logic delay_active;

   // Genuineness keys sit above the application key range
   function automatic logic is_genuine(input logic [2:0] k);
      return k >= SAN_ORIG_KEY_BASE;
   endfunction

   // Saturating subtraction of the decrement
   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? 16'(a - b) : 16'h0000;
   endfunction

   assign take = req_valid && (state_reg == SAN_IDLE);
   assign is_first = take && (req.kind == SAN_CMD_FIRST);
   assign is_followon = take && (req.kind == SAN_CMD_FOLLOWON);
   assign is_result = take && (req.kind == SAN_CMD_RESULT) && pending_reg;
   assign genuine_key = is_genuine(req.key_no);
   assign key_ok = genuine_key || (req.key_no < 3'(SAN_NUM_KEYS)
      && !key_blocked[req.key_no]);
   assign reader_wants_res = req.cap_present && req.reader_cap[SAN_CAP_MODE_BIT];
   assign fail_event = is_result && !req.auth_ok;
   assign ok_event = is_result && req.auth_ok;
   // delay answers owed until budget spent
   assign delay_active = throttling && (delay_spent_reg < delay_total_reg);
   assign timer_start = delay_active && (is_first || is_followon);

   san_delay_timer u_delay (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .start(timer_start),
      .fwt_cycles(fwt_cycles),
      .busy(),
      .done(timer_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // Configuration
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resilient_enabled <= 1'b0;
         failed_auth_limit_reg <= 16'hffff;
         failed_auth_decrement_reg <= 16'h0000;
      end else if (take && req.kind == SAN_CMD_CONFIGURE) begin
         if (req.cfg_resilient) begin
            resilient_enabled <= 1'b1;
         end
         failed_auth_limit_reg <= req.cfg_limit;
         failed_auth_decrement_reg <= req.cfg_decrement;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Total failure counter
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         total_failed_auth_count <= SAN_FAIL_RESET;
      end else if (fail_event) begin
         if (total_failed_auth_count != 16'hffff) begin
            total_failed_auth_count <= total_failed_auth_count + 16'h1;
         end
      end else if (ok_event && !pending_resilient_reg) begin
         total_failed_auth_count <= sat_sub(total_failed_auth_count,
            failed_auth_decrement_reg);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Key blocking
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         key_blocked <= '0;
      end else begin
         if (fail_event && !is_genuine(pending_key_reg)
            && total_failed_auth_count + 16'h1 >= failed_auth_limit_reg) begin
            key_blocked[pending_key_reg] <= 1'b1;
         end
         // replace clears block under master session
         if (take && req.kind == SAN_CMD_KEY_REPLACE && authenticated
            && session_key_reg == SAN_MASTER_KEY && !key_blocked[SAN_MASTER_KEY]
            && req.key_no != SAN_MASTER_KEY && req.key_no < 3'(SAN_NUM_KEYS)) begin
            key_blocked[req.key_no] <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Session and pending authentication
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         authenticated <= 1'b0;
         session_resilient_reg <= 1'b0;
         session_key_reg <= 3'h0;
         pending_reg <= 1'b0;
         pending_resilient_reg <= 1'b0;
         pending_key_reg <= 3'h0;
      end else if (take && !delay_active) begin
         case (req.kind)
            SAN_CMD_FIRST: begin
               if (key_ok && !(!reader_wants_res && resilient_enabled)) begin
                  pending_reg <= 1'b1;
                  pending_resilient_reg <= resilient_enabled;
                  pending_key_reg <= req.key_no;
                  authenticated <= 1'b0;
               end
            end
            SAN_CMD_FOLLOWON: begin
               // follow-on needs session or genuineness key
               if (key_ok && (authenticated || genuine_key)) begin
                  pending_reg <= 1'b1;
                  pending_resilient_reg <= authenticated ? session_resilient_reg : 1'b1;
                  pending_key_reg <= req.key_no;
               end
            end
            SAN_CMD_RESULT: begin
               pending_reg <= 1'b0;
               if (pending_reg) begin
                  authenticated <= req.auth_ok;
                  if (req.auth_ok) begin
                     session_resilient_reg <= pending_resilient_reg;
                     session_key_reg <= pending_key_reg;
                  end
               end
            end
            SAN_CMD_DEAUTH: begin
               authenticated <= 1'b0;
               pending_reg <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Consecutive failures and delay budget
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         consec_fail_reg <= SAN_CONSEC_RESET;
         delay_total_reg <= 24'h000000;
         delay_spent_reg <= 24'h000000;
         throttling <= 1'b0;
      end else begin
         if (ok_event) begin
            consec_fail_reg <= SAN_CONSEC_RESET;
            delay_total_reg <= 24'h000000;
            delay_spent_reg <= 24'h000000;
            throttling <= 1'b0;
         end else if (fail_event) begin
            if (consec_fail_reg != 8'hff) begin
               consec_fail_reg <= consec_fail_reg + 8'h1;
            end
            if (consec_fail_reg + 8'h1 >= CONSEC_LIMIT) begin
               throttling <= 1'b1;
               delay_spent_reg <= 24'h000000;
               delay_total_reg <= (delay_total_reg + SAN_DELAY_STEP > DELAY_MAX)
                  ? DELAY_MAX : 24'(delay_total_reg + SAN_DELAY_STEP);
            end
         end else if (timer_done && throttling) begin
            delay_spent_reg <= (delay_total_reg - delay_spent_reg <= fwt_cycles)
               ? delay_total_reg : 24'(delay_spent_reg + fwt_cycles);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Answer state machine
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SAN_IDLE;
      end else begin
         case (state_reg)
            SAN_IDLE: begin
               if (timer_start) begin
                  state_reg <= SAN_WAIT_DELAY;
               end
            end
            SAN_WAIT_DELAY: begin
               if (timer_done) begin
                  state_reg <= SAN_IDLE;
               end
            end
            default: state_reg <= SAN_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Answer formation
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= 1'b0;
         rsp.wait_cycles <= fwt_cycles;
         rsp.card_cap <= resilient_enabled ? SAN_CAP_RESILIENT : SAN_CAP_AES;
         if (state_reg == SAN_WAIT_DELAY && timer_done) begin
            rsp_valid <= 1'b1;
            rsp.status <= SAN_ST_AUTH_DELAY;
            rsp.length <= SAN_LEN_STATUS;
            rsp.has_auth_type <= 1'b0;
         end else if (take && !delay_active) begin
            rsp_valid <= 1'b1;
            rsp.has_auth_type <= 1'b0;
            rsp.auth_type <= 8'h00;
            rsp.reader_cap <= reader_wants_res ? SAN_CAP_RESILIENT : SAN_CAP_AES;
            rsp.status <= SAN_ST_OK;
            rsp.length <= SAN_LEN_STATUS;
            if (is_first) begin
               if (!key_ok) begin
                  rsp.status <= SAN_ST_REFUSED;
               end else if (!reader_wants_res && resilient_enabled) begin
                  rsp.status <= SAN_ST_REFUSED;
               end else if (resilient_enabled) begin
                  rsp.status <= SAN_ST_MORE_FRAMES;
                  rsp.length <= SAN_LEN_RESILIENT;
                  rsp.has_auth_type <= 1'b1;
                  rsp.auth_type <= SAN_AUTH_TYPE_RESILIENT;
                  rsp.resilient <= 1'b1;
               end else begin
                  rsp.status <= SAN_ST_MORE_FRAMES;
                  rsp.length <= SAN_LEN_AES;
                  rsp.resilient <= 1'b0;
               end
            end else if (is_followon) begin
               if (key_ok && (authenticated || genuine_key)) begin
                  rsp.status <= SAN_ST_MORE_FRAMES;
                  rsp.resilient <= authenticated ? session_resilient_reg : 1'b1;
                  rsp.length <= SAN_LEN_AES;
               end else begin
                  rsp.status <= SAN_ST_REFUSED;
               end
            end else if (req.kind == SAN_CMD_RESULT) begin
               rsp.status <= (pending_reg && req.auth_ok) ? SAN_ST_OK : SAN_ST_AUTH_ERROR;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   a_mode_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      resilient_enabled |=> resilient_enabled) else $error("mode reverted");
   a_fail_counts: assert property (@(posedge core_clk) disable iff (!reset_n)
      fail_event && total_failed_auth_count != 16'hffff
      |=> total_failed_auth_count == $past(total_failed_auth_count) + 16'h1)
      else $error("failure not counted");
   a_aes_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_first && !delay_active && key_ok && resilient_enabled && !reader_wants_res
      |=> rsp_valid && rsp.status == SAN_ST_REFUSED) else $error("no refusal");
   a_res_length: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_first && !delay_active && key_ok && resilient_enabled && reader_wants_res
      |=> rsp.length == SAN_LEN_RESILIENT && rsp.auth_type == SAN_AUTH_TYPE_RESILIENT)
      else $error("bad resilient answer");
   a_aes_length: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_first && !delay_active && key_ok && !resilient_enabled
      |=> rsp.length == SAN_LEN_AES && rsp.card_cap == SAN_CAP_AES)
      else $error("bad AES answer");
   a_followon_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_followon && !delay_active && !authenticated && !genuine_key
      |=> rsp.status == SAN_ST_REFUSED) else $error("follow-on not gated");
   a_throttle_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      throttling && !ok_event |=> throttling) else $error("throttle left");
   a_delay_status: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_reg == SAN_WAIT_DELAY && timer_done
      |=> rsp_valid && rsp.status == SAN_ST_AUTH_DELAY) else $error("no delay");
   a_master_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
      key_blocked[SAN_MASTER_KEY] |=> key_blocked[SAN_MASTER_KEY])
      else $error("master unblocked");

endmodule

// ==== san_reader_model.sv ====
// Reader-side model that issues authentication commands and collects answers
`timescale 1ns/1ps
module san_reader_model
   import san_pkg::*;
#(
   parameter logic [15:0] LIMIT = 16'h0004,
   parameter logic [15:0] DECR = 16'h0001
)
(
   // Clock
   input wire logic core_clk,
   // Command side
   output logic req_valid,
   output san_req_t req,
   // Answer side
   input wire logic rsp_valid,
   input wire san_rsp_t rsp
);
   // Idle bus carries a pattern unlike any real command
   initial begin
      req_valid = 1'b0;
      req = '1;
   end

   //////////////////////////////////////////////////////////////////////
   // Issue one command and wait a bounded time for its answer
   task automatic issue(input san_cmd_t kind, input logic [2:0] key, input logic capp,
         input logic [7:0] cap, input logic ok, input logic cres,
         output logic got, output int lat, output logic resm);
      san_req_t r;
      r = '0;
      r.kind = kind;
      r.key_no = key;
      r.cap_present = capp;
      r.reader_cap = capp ? cap : 8'h00;
      r.auth_ok = ok;
      r.cfg_resilient = cres;
      r.cfg_limit = LIMIT;
      r.cfg_decrement = DECR;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= r;
      got = 1'b0;
      lat = 0;
      while (!got && lat < 400) begin
         @(posedge core_clk);
         // Released bus must not keep showing the command
         if (lat == 0) begin
            req_valid <= 1'b0;
            req <= ~r;
         end
         #1;
         if (rsp_valid === 1'b1) got = 1'b1;
         else lat++;
      end
      resm = got && (rsp.length === SAN_LEN_RESILIENT);
   endtask
endmodule

// ==== tb_secure_auth_negotiation.sv ====
// Self-checking bench for the authentication negotiation block
`timescale 1ns/1ps
module tb_secure_auth_negotiation;
   import san_pkg::*;
   // Clock, reset, frame wait of 128 cycles
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [23:0] fwt_cycles = 24'h000080;
   // Block ports
   logic req_valid;
   san_req_t req;
   logic rsp_valid;
   san_rsp_t rsp;
   logic resilient_enabled;
   logic authenticated;
   logic throttling;
   logic [15:0] total_failed_auth_count;
   logic [SAN_NUM_KEYS-1:0] key_blocked;
   // Bookkeeping
   int failures = 0;
   int num_checks = 0;
   logic got;
   logic resm;
   int lat;
   int ndel;
   localparam int DLY = (128 * 65) / 100;

   always #4 core_clk = ~core_clk;

   san_negotiator #(.CONSEC_LIMIT(8'h03), .DELAY_MAX(24'h000200)) dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .fwt_cycles(fwt_cycles), .rsp_valid(rsp_valid), .rsp(rsp),
      .resilient_enabled(resilient_enabled), .authenticated(authenticated),
      .throttling(throttling), .total_failed_auth_count(total_failed_auth_count),
      .key_blocked(key_blocked));

   san_reader_model rdr_u (.core_clk(core_clk), .req_valid(req_valid), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp));

   //////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask

   // One command through the reader model
   task automatic send(input san_cmd_t k, input logic [2:0] key, input logic capp,
         input logic [7:0] cap, input logic ok, input logic cres);
      rdr_u.issue(k, key, capp, cap, ok, cres, got, lat, resm);
   endtask

   // Verdict, reached from the tests and from the watchdog
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: tests need a few hundred cycles
   initial begin
      #400000;
      failures++;
      wrap_up();
   end

   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      check(rsp == '0, 1, "reset answer");
      check(total_failed_auth_count, 0, "reset count");
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      send(SAN_CMD_CONFIGURE, 3'h1, 0, 8'h00, 0, 0);
      check(resilient_enabled, 0, "mode after aes config");
      // Both AES, reader omits capability
      send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
      check({rsp.status, rsp.length, rsp.has_auth_type}, {SAN_ST_MORE_FRAMES, SAN_LEN_AES, 1'b0}, "aes first");
      check({rsp.card_cap, rsp.reader_cap, resm}, 0, "aes caps");
      send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 1, 0);
      check(authenticated, 1, "authenticated");
      send(SAN_CMD_FOLLOWON, 3'h1, 0, 8'h00, 0, 0);
      check({rsp.status, rsp.resilient}, {SAN_ST_MORE_FRAMES, 1'b0}, "aes followon");
      // Resilient asked, AES configured, while already authenticated
      send(SAN_CMD_FIRST, 3'h1, 1, SAN_CAP_RESILIENT, 0, 0);
      check({rsp.status, rsp.length, rsp.card_cap, rsp.reader_cap}, {SAN_ST_MORE_FRAMES, SAN_LEN_AES, SAN_CAP_AES, SAN_CAP_RESILIENT}, "fallback");
      send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 1, 0);
      // Follow-on without a session, then with a genuineness key
      send(SAN_CMD_DEAUTH, 3'h1, 0, 8'h00, 0, 0);
      send(SAN_CMD_FOLLOWON, 3'h1, 0, 8'h00, 0, 0);
      check(rsp.status, SAN_ST_REFUSED, "unauth followon");
      send(SAN_CMD_FOLLOWON, 3'h5, 0, 8'h00, 0, 0);
      check({rsp.status, rsp.resilient}, {SAN_ST_MORE_FRAMES, 1'b1}, "genuineness");
      send(SAN_CMD_RESULT, 3'h5, 0, 8'h00, 1, 0);
      // Failure counting, decrement on success, blocking at limit 4
      repeat (2) begin
         send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
         send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 0, 0);
      end
      check(total_failed_auth_count, 2, "count up");
      send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
      send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 1, 0);
      check(total_failed_auth_count, 1, "decrement");
      repeat (3) begin
         send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
         send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 0, 0);
      end
      check({key_blocked[1], total_failed_auth_count}, {1'b1, 16'h0004}, "blocked");
      check(throttling, 1, "throttle on");
      // Delay answers stretched, bounded by the total delay cap
      ndel = 0;
      got = 1'b1;
      while (ndel < 20 && got) begin
         send(SAN_CMD_FIRST, 3'h2, 0, 8'h00, 0, 0);
         if (rsp.status !== SAN_ST_AUTH_DELAY) break;
         ndel++;
         check(lat >= DLY - 1 && lat <= DLY + 2, 1, "delay time");
         check(rsp.wait_cycles, fwt_cycles, "delay wait");
      end
      check(ndel > 0 && ndel <= 4, 1, "delay count");
      check(rsp.status, SAN_ST_MORE_FRAMES, "after delay");
      send(SAN_CMD_RESULT, 3'h2, 0, 8'h00, 1, 0);
      check(throttling, 0, "throttle off");
      // Blocked key refused, then recovered by the master key
      send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
      check(rsp.status, SAN_ST_REFUSED, "blocked key");
      send(SAN_CMD_FIRST, 3'h0, 0, 8'h00, 0, 0);
      send(SAN_CMD_RESULT, 3'h0, 0, 8'h00, 1, 0);
      send(SAN_CMD_KEY_REPLACE, 3'h1, 0, 8'h00, 0, 0);
      check(key_blocked[1], 0, "unblocked");
      send(SAN_CMD_FIRST, 3'h1, 0, 8'h00, 0, 0);
      check(rsp.status, SAN_ST_MORE_FRAMES, "usable again");
      send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 1, 0);
      // Resilient mode, sticky
      send(SAN_CMD_CONFIGURE, 3'h1, 0, 8'h00, 0, 1);
      check(resilient_enabled, 1, "mode set");
      send(SAN_CMD_FIRST, 3'h1, 1, SAN_CAP_AES, 0, 0);
      check(rsp.status, SAN_ST_REFUSED, "aes refused");
      send(SAN_CMD_FIRST, 3'h1, 1, SAN_CAP_RESILIENT, 0, 0);
      check({rsp.status, rsp.length, rsp.has_auth_type, rsp.auth_type}, {SAN_ST_MORE_FRAMES, SAN_LEN_RESILIENT, 1'b1, SAN_AUTH_TYPE_RESILIENT}, "lrp");
      check({rsp.card_cap[SAN_CAP_MODE_BIT], rsp.reader_cap, resm}, {1'b1, SAN_CAP_RESILIENT, 1'b1}, "lrp caps");
      send(SAN_CMD_RESULT, 3'h1, 0, 8'h00, 1, 0);
      send(SAN_CMD_FOLLOWON, 3'h1, 0, 8'h00, 0, 0);
      check({rsp.status, rsp.resilient}, {SAN_ST_MORE_FRAMES, 1'b1}, "lrp followon");
      send(SAN_CMD_CONFIGURE, 3'h1, 0, 8'h00, 0, 0);
      check(resilient_enabled, 1, "mode sticky");
      wrap_up();
   end
endmodule
